/* dv/board_model.sv */
// Board-side model of the ten I/O pins that drives a pin the array lets go of only while its ext_en bit is set.
`timescale 1ns/100ps
module board_model (
  input wire logic core_clk,
  input wire logic [pld_pkg::NUM_MC-1:0] io_out,
  input wire logic [pld_pkg::NUM_MC-1:0] io_oe,
  input wire logic [pld_pkg::NUM_MC-1:0] ext_val,
  input wire logic [pld_pkg::NUM_MC-1:0] ext_en,
  output logic [pld_pkg::NUM_MC-1:0] io_in,
  output logic [pld_pkg::NUM_MC-1:0] io_driven
);
  logic [pld_pkg::NUM_MC-1:0] last_reg;
  // A released line has no pull, so it shows the inverse of its last level.
  // Only a keeper can hold it.
  assign io_in = (io_oe & io_out) | (~io_oe & ext_en & ext_val) |
                 (~io_oe & ~ext_en & ~last_reg);
  assign io_driven = io_oe | ext_en;
  // The last wire level is remembered once per clock.
  always_ff @(posedge core_clk) begin
    last_reg <= io_in;
  end
endmodule : board_model

/* dv/test_sum_of_products_logic_array.sv */
// Self-checking testbench of the sum-of-products logic array.
`timescale 1ns/100ps
module test_sum_of_products_logic_array;
  localparam int IDLE = 16;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] in_pin = 12'h000;
  logic [11:0] in_drv = 12'hfff;
  logic [9:0] io_in, io_out, io_oe, io_drv;
  logic [9:0] io_ext_en = 10'h3ff;
  logic preload_en = 1'b0;
  logic [9:0] preload_data = 10'h000;
  logic prog_we = 1'b0;
  logic prog_erase = 1'b0;
  logic [6:0] prog_row = 7'h00;
  pld_pkg::row_t prog_data = 44'h0;
  logic prog_secure_set = 1'b0;
  logic prog_rd_en = 1'b0;
  pld_pkg::row_t rd_data;
  logic rd_valid, rd_refused, secured, standby;
  int mismatches = 0;
  int n_checks = 0;

  pld_top #(.IDLE_CYCLES(IDLE)) DUT (.core_clk(core_clk), .reset_n(reset_n), .in_pin(in_pin),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .pin_driven({io_drv, in_drv}),
    .preload_en(preload_en), .preload_data(preload_data), .prog_we(prog_we),
    .prog_erase(prog_erase), .prog_row(prog_row), .prog_data(prog_data),
    .prog_secure_set(prog_secure_set), .prog_rd_en(prog_rd_en), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_refused(rd_refused), .secured(secured), .standby(standby));
  board_model board (.core_clk(core_clk), .io_out(io_out), .io_oe(io_oe), .ext_val(10'h000),
    .ext_en(io_ext_en), .io_in(io_in), .io_driven(io_drv));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Outputs are sampled on the falling edge, well away from the launching edge.
  task cy(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : cy
  task chk(input pld_pkg::row_t got, input pld_pkg::row_t exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task prog(input logic [6:0] row, input pld_pkg::row_t d);
    @(posedge core_clk);
    prog_we <= 1'b1;
    prog_row <= row;
    prog_data <= d;
    @(posedge core_clk);
    prog_we <= 1'b0;
  endtask : prog
  task erase();
    @(posedge core_clk);
    prog_erase <= 1'b1;
    @(posedge core_clk);
    prog_erase <= 1'b0;
  endtask : erase
  // A pin needs three edges to reach the array; six leave room for the registered path too.
  task pin(input int i, input logic v);
    @(posedge core_clk);
    in_pin[i] <= v;
    cy(6);
  endtask : pin
  task pre(input logic [9:0] d);
    @(posedge core_clk);
    preload_en <= 1'b1;
    preload_data <= d;
    repeat (2) @(posedge core_clk);
    preload_en <= 1'b0;
    cy(2);
  endtask : pre
  task rd(input logic [6:0] row);
    int k;
    @(posedge core_clk);
    prog_rd_en <= 1'b1;
    prog_row <= row;
    @(posedge core_clk);
    prog_rd_en <= 1'b0;
    @(negedge core_clk);
    k = 0;
    while (!(rd_valid === 1'b1 || rd_refused === 1'b1) && k < 4) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 4) begin
      mismatches++;
      $display("BAD t=%0t readback never answered", $time);
      final_report();
    end
  endtask : rd
  task final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset();
    cy(1);
    chk(44'({io_out, io_oe, standby, secured, rd_valid}), 44'h0, "out of reset");
    prog(7'h7a, 44'h3ff003ff);
    pre(10'h3ff);
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    cy(1);
    chk(44'({io_out, io_oe}), 44'h0, "mid-run reset");
    $display("test reset done");
  endtask : t_reset
  // Last row of the first and of the last macrocell; each reaches its own output only.
  task t_comb();
    erase();
    prog(7'h07, 44'h4);
    prog(7'h77, 44'h4);
    prog(7'h7a, 44'h20100000);
    pin(1, 1'b1);
    chk(44'(io_out), 44'h201, "comb high");
    chk(44'(io_oe), 44'h201, "comb enable");
    pin(1, 1'b0);
    chk(44'(io_out), 44'h0, "comb low");
    $display("test comb done");
  endtask : t_comb
  // An undriven pin that drifts must not change the output.
  task t_keep();
    pin(1, 1'b1);
    @(posedge core_clk);
    in_drv[1] <= 1'b0;
    in_pin[1] <= 1'b0;
    cy(6);
    chk(44'(io_out), 44'h201, "keeper hold");
    @(posedge core_clk);
    in_drv[1] <= 1'b1;
    cy(6);
    chk(44'(io_out), 44'h0, "driven again");
    // A released I/O pin flickers on the wire; only its keeper lets the array fall asleep.
    @(posedge core_clk);
    io_ext_en[4] <= 1'b0;
    cy(IDLE + 8);
    chk(44'(standby), 44'h1, "floating pin kept");
    @(posedge core_clk);
    io_ext_en[4] <= 1'b1;
    cy(2);
    $display("test keep done");
  endtask : t_keep
  task t_reg();
    erase();
    prog(7'h7a, 44'h3ff003ff);
    prog(7'h07, 44'h4);
    prog(7'h78, 44'h10);
    pin(1, 1'b1);
    pin(0, 1'b1);
    pin(0, 1'b0);
    chk(44'(io_out), 44'h001, "registered");
    chk(44'(io_oe), 44'h3ff, "all enabled");
    pre(10'h3ff);
    chk(44'(io_out), 44'h3ff, "preload");
    pin(2, 1'b1);
    pin(0, 1'b1);
    pin(0, 1'b0);
    chk(44'(io_out), 44'h0, "sync clear");
    pin(1, 1'b0);
    pin(2, 1'b0);
    $display("test reg done");
  endtask : t_reg
  task t_async();
    erase();
    prog(7'h7a, 44'h3ff003ff);
    prog(7'h79, 44'h40);
    pre(10'h2a5);
    chk(44'(io_out), 44'h2a5, "preload");
    pin(3, 1'b1);
    chk(44'(io_out), 44'h0, "async clear");
    pin(3, 1'b0);
    $display("test async done");
  endtask : t_async
  task t_standby();
    int k;
    erase();
    prog(7'h7a, 44'h3ff003ff);
    pre(10'h155);
    k = 0;
    while (standby !== 1'b1 && k < IDLE + 10) begin
      cy(1);
      k++;
    end
    chk(44'(standby), 44'h1, "asleep");
    if (k == IDLE + 10) begin
      final_report();
    end
    chk(44'(io_out), 44'h155, "sleep kept");
    pin(5, 1'b1);
    chk(44'(standby), 44'h0, "woken");
    chk(44'(io_out), 44'h155, "wake kept");
    $display("test standby done");
  endtask : t_standby
  task t_secure();
    erase();
    prog(7'h05, 44'h123);
    rd(7'h05);
    chk(44'(rd_valid), 44'h1, "readback valid");
    chk(rd_data, 44'h123, "readback");
    prog(7'h07, 44'h4);
    prog(7'h7a, 44'h100000);
    @(posedge core_clk);
    prog_secure_set <= 1'b1;
    @(posedge core_clk);
    prog_secure_set <= 1'b0;
    cy(1);
    chk(44'(secured), 44'h1, "secured");
    rd(7'h05);
    chk(44'(rd_refused), 44'h1, "refused");
    chk(rd_data, 44'h0, "refused data");
    pin(1, 1'b1);
    chk(44'(io_out), 44'h001, "logic runs");
    $display("test secure done");
  endtask : t_secure

  // ****************************************************************
  // Clock and main sequence
  // ****************************************************************
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_comb();
    t_keep();
    t_reg();
    t_async();
    t_standby();
    t_secure();
    final_report();
  end
endmodule : test_sum_of_products_logic_array

/* hdl/pld_top.sv */
// Ten-macrocell sum-of-products logic array with standby, keepers and preload.
//
// How it works
// - Each output ORs its own fixed share of eight to sixteen product terms.
// - Two extra terms clear registers: one on the clock edge, one at once.
// - Both clear terms act on all ten macrocell registers together.
// - Reset brings shared clear logic and all macrocell registers to cleared.
// - Preload writes arbitrary values straight into the macrocell registers.
// - With security set, pattern readback is refused; logic runs unchanged.
// - Idle inputs put the array in standby; an edge on any driven input wakes it.
// - Keepers hold each undriven pin at its last driven level.
`timescale 1ns/100ps
module pld_top #(
  parameter int IDLE_CYCLES = pld_pkg::IDLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [pld_pkg::NUM_IN-1:0] in_pin,
  input wire logic [pld_pkg::NUM_MC-1:0] io_in,
  output logic [pld_pkg::NUM_MC-1:0] io_out,
  output logic [pld_pkg::NUM_MC-1:0] io_oe,
  input wire logic [pld_pkg::NUM_PIN-1:0] pin_driven,
  input wire logic preload_en,
  input wire logic [pld_pkg::NUM_MC-1:0] preload_data,
  input wire logic prog_we,
  input wire logic prog_erase,
  input wire logic [pld_pkg::ROW_W-1:0] prog_row,
  input wire pld_pkg::row_t prog_data,
  input wire logic prog_secure_set,
  input wire logic prog_rd_en,
  output pld_pkg::row_t rd_data,
  output logic rd_valid,
  output logic rd_refused,
  output logic secured,
  output logic standby
);
  typedef struct packed {
    logic [pld_pkg::NUM_PIN-1:0] sync1;
    logic [pld_pkg::NUM_PIN-1:0] sync2;
    logic [pld_pkg::NUM_PIN-1:0] drv1;
    logic [pld_pkg::NUM_PIN-1:0] drv2;
    logic [pld_pkg::NUM_PIN-1:0] keep;
    logic clk_prev;
    logic [pld_pkg::NUM_MC-1:0] mc_q;
    logic [pld_pkg::NUM_MC-1:0] sel;
    logic [pld_pkg::NUM_MC-1:0] drive;
    logic [pld_pkg::NUM_MC-1:0] oe;
    logic [pld_pkg::CNT_W-1:0] idle_cnt;
    logic standby;
    logic secured;
    pld_pkg::row_t rd_data;
    logic rd_valid;
    logic rd_refused;
  } top_state_t;

  top_state_t st_reg;
  top_state_t st_next;
  logic clk_edge;
  logic input_edge_wake_detect;
  logic [pld_pkg::NUM_MC-1:0] cfg_clocked;
  logic [pld_pkg::NUM_MC-1:0] cfg_inv;
  logic [pld_pkg::NUM_MC-1:0] cfg_oe;
  logic [pld_pkg::NUM_LIT-1:0] lits;

  pterm_if ifc ();

  pterm_array u_array (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .ifc(ifc.arr)
  );

  // ****************************************************************
  // Array hookup
  // ****************************************************************
  // Feedback is the selected macrocell value held in a flip-flop, which
  // breaks the loop a combinational feedback path would otherwise form.
  assign lits = {st_reg.sel, st_reg.keep[pld_pkg::NUM_IN-1:0]};
  for (genvar i = 0; i < pld_pkg::NUM_LIT; i++) begin : g_col
    assign ifc.cols[2*i] = lits[i];
    assign ifc.cols[2*i+1] = ~lits[i];
  end

  // Programming port goes straight to the pattern store.
  assign ifc.wr_en = prog_we;
  assign ifc.erase = prog_erase;
  assign ifc.wr_row = prog_row;
  assign ifc.wr_data = prog_data;
  assign ifc.rd_row = prog_row;
  assign cfg_clocked = ifc.cfg[pld_pkg::CFG_REG_POS +: pld_pkg::NUM_MC];
  assign cfg_inv = ifc.cfg[pld_pkg::CFG_INV_POS +: pld_pkg::NUM_MC];
  assign cfg_oe = ifc.cfg[pld_pkg::CFG_OE_POS +: pld_pkg::NUM_MC];

  // Pin clock rising edge, seen on the kept and synchronised clock pin.
  assign clk_edge = st_reg.keep[pld_pkg::CLK_LIT] & ~st_reg.clk_prev;
  assign input_edge_wake_detect = (st_next.keep != st_reg.keep);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    // Pins come from another domain, so both values pass two flip-flops.
    st_next.sync1 = {io_in, in_pin};
    st_next.sync2 = st_reg.sync1;
    st_next.drv1 = pin_driven;
    st_next.drv2 = st_reg.drv1;
    st_next.keep = (st_reg.sync2 & st_reg.drv2) | (st_reg.keep & ~st_reg.drv2);
    st_next.clk_prev = st_reg.keep[pld_pkg::CLK_LIT];
    // Idle detection; a kept level that changes is the only wake source.
    if (st_next.keep != st_reg.keep) begin
      st_next.standby = 1'b0;
      st_next.idle_cnt = '0;
    end else if (!st_reg.standby) begin
      if (st_reg.idle_cnt == pld_pkg::CNT_W'(IDLE_CYCLES - 1)) begin
        st_next.standby = 1'b1;
        st_next.idle_cnt = '0;
      end else begin
        st_next.idle_cnt = st_reg.idle_cnt + 1'b1;
      end
    end
    // Register update; the immediate clear beats preload and the pin clock.
    // Standby freezes everything except preload, which is not an input edge.
    if (!st_reg.standby && ifc.async_clr) begin
      st_next.mc_q = '0;
    end else if (preload_en) begin
      st_next.mc_q = preload_data;
    end else if (!st_reg.standby && clk_edge) begin
      st_next.mc_q = ifc.sync_clr ? '0 : ifc.sums;
    end
    // Output select, polarity and enable, held while in standby.
    if (!st_reg.standby) begin
      st_next.sel = (st_reg.mc_q & cfg_clocked) | (ifc.sums & ~cfg_clocked);
      st_next.drive = st_next.sel ^ cfg_inv;
      st_next.oe = cfg_oe;
    end
    // Readback; once secured the pattern never leaves, logic is untouched.
    st_next.rd_valid = 1'b0;
    st_next.rd_refused = 1'b0;
    if (prog_rd_en) begin
      if (st_reg.secured) begin
        st_next.rd_refused = 1'b1;
        st_next.rd_data = '0;
      end else begin
        st_next.rd_valid = 1'b1;
        st_next.rd_data = ifc.rd_data;
      end
    end
    // Setting security wins over an erase in the same cycle.
    st_next.secured = prog_secure_set | (st_reg.secured & ~prog_erase);
  end

  // Synchronous reset clears everything, the macrocells among them.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign io_out = st_reg.drive;
  assign io_oe = st_reg.oe;
  assign rd_data = st_reg.rd_data;
  assign rd_valid = st_reg.rd_valid;
  assign rd_refused = st_reg.rd_refused;
  assign secured = st_reg.secured;
  assign standby = st_reg.standby;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_async_clr;
    @(posedge core_clk) disable iff (!reset_n)
    (ifc.async_clr && !st_reg.standby) |=> (st_reg.mc_q == '0);
  endproperty
  a_async_clr: assert property (p_async_clr) else $error("async clear missed");

  property p_sync_clr;
    @(posedge core_clk) disable iff (!reset_n)
    (!st_reg.standby && clk_edge && ifc.sync_clr && !ifc.async_clr && !preload_en)
      |=> (st_reg.mc_q == '0);
  endproperty
  a_sync_clr: assert property (p_sync_clr) else $error("sync clear missed");

  property p_sum_load;
    @(posedge core_clk) disable iff (!reset_n)
    (!st_reg.standby && clk_edge && !ifc.sync_clr && !ifc.async_clr && !preload_en)
      |=> (st_reg.mc_q == $past(ifc.sums));
  endproperty
  a_sum_load: assert property (p_sum_load) else $error("sum not registered");

  property p_reset;
    @(posedge core_clk) disable iff (!reset_n)
    $rose(reset_n) |-> (st_reg.mc_q == '0 && st_reg.oe == '0 && !st_reg.standby);
  endproperty
  a_reset: assert property (p_reset) else $error("not cleared after reset");

  property p_preload;
    @(posedge core_clk) disable iff (!reset_n)
    (preload_en && !(ifc.async_clr && !st_reg.standby))
      |=> (st_reg.mc_q == $past(preload_data));
  endproperty
  a_preload: assert property (p_preload) else $error("preload lost");

  property p_secure;
    @(posedge core_clk) disable iff (!reset_n)
    (prog_rd_en && st_reg.secured) |=> (rd_refused && !rd_valid && rd_data == '0);
  endproperty
  a_secure: assert property (p_secure) else $error("secured pattern read");

  localparam int IDLE_LAST = IDLE_CYCLES - 1;
  property p_enter;
    @(posedge core_clk) disable iff (!reset_n)
    $rose(st_reg.standby) |-> ($past(st_reg.idle_cnt) == IDLE_LAST);
  endproperty
  a_enter: assert property (p_enter) else $error("standby entered early");

  property p_wake;
    @(posedge core_clk) disable iff (!reset_n)
    (st_reg.standby && input_edge_wake_detect) |=> !st_reg.standby;
  endproperty
  a_wake: assert property (p_wake) else $error("edge did not wake");

  property p_keeper;
    @(posedge core_clk) disable iff (!reset_n)
    1'b1 |=> (((st_reg.keep ^ $past(st_reg.keep)) & ~$past(st_reg.drv2)) == '0);
  endproperty
  a_keeper: assert property (p_keeper) else $error("undriven pin moved");

  property p_select;
    @(posedge core_clk) disable iff (!reset_n)
    !st_reg.standby |=> (st_reg.sel == (($past(st_reg.mc_q) & $past(cfg_clocked)) |
                                       ($past(ifc.sums) & ~$past(cfg_clocked))));
  endproperty
  a_select: assert property (p_select) else $error("wrong output select");

  property p_hold;
    @(posedge core_clk) disable iff (!reset_n)
    (st_reg.standby && !preload_en) |=> ($stable(st_reg.mc_q) && $stable(st_reg.drive));
  endproperty
  a_hold: assert property (p_hold) else $error("standby changed state");

  c_standby: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(st_reg.standby));
  c_wake: cover property (@(posedge core_clk) disable iff (!reset_n) $fell(st_reg.standby));
  c_refused: cover property (@(posedge core_clk) disable iff (!reset_n) rd_refused);
  c_clock: cover property (@(posedge core_clk) disable iff (!reset_n)
    clk_edge && !st_reg.standby && ifc.sums != '0);
endmodule : pld_top

/* hdl/pterm_array.sv */
// Programmable AND plane and per-output OR gates with the shared clear terms.
`timescale 1ns/100ps
module pterm_array (
  input wire logic core_clk,
  input wire logic reset_n,
  pterm_if.arr ifc
);
  typedef struct packed {
    pld_pkg::row_t [pld_pkg::NUM_ROWS-1:0] fuse;
  } arr_state_t;

  arr_state_t st_reg;
  arr_state_t st_next;
  logic [pld_pkg::CFG_ROW-1:0] term;

  // ****************************************************************
  // Pattern store
  // ****************************************************************
  // Erase wins over a write so that a bulk erase is never half done.
  always_comb begin
    st_next = st_reg;
    if (ifc.erase) begin
      st_next.fuse = '0;
    end else if (ifc.wr_en && ifc.wr_row < pld_pkg::ROW_W'(pld_pkg::NUM_ROWS)) begin
      st_next.fuse[ifc.wr_row] = ifc.wr_data;
    end
  end

  // The pattern comes up erased; it is loaded again after every power-up.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Product terms
  // ****************************************************************
  // A row with no connection at all is off, so an erased row never fires.
  for (genvar r = 0; r < pld_pkg::CFG_ROW; r++) begin : g_term
    assign term[r] = (st_reg.fuse[r] != '0) &&
                     ((ifc.cols & st_reg.fuse[r]) == st_reg.fuse[r]);
  end

  // Each output ORs only its own fixed share of rows.
  for (genvar m = 0; m < pld_pkg::NUM_MC; m++) begin : g_sum
    logic [pld_pkg::MAX_PT-1:0] hit;
    for (genvar k = 0; k < pld_pkg::MAX_PT; k++) begin : g_hit
      if (k < pld_pkg::PT_COUNT[m]) begin : g_used
        assign hit[k] = term[pld_pkg::PT_BASE[m] + k];
      end else begin : g_unused
        assign hit[k] = 1'b0;
      end
    end
    assign ifc.sums[m] = |hit;
  end

  // The two shared clear rows and the configuration row.
  assign ifc.sync_clr = term[pld_pkg::SYNC_CLR_ROW];
  assign ifc.async_clr = term[pld_pkg::ASYNC_CLR_ROW];
  assign ifc.cfg = st_reg.fuse[pld_pkg::CFG_ROW][pld_pkg::CFG_W-1:0];
  assign ifc.rd_data = (ifc.rd_row < pld_pkg::ROW_W'(pld_pkg::NUM_ROWS)) ?
                       st_reg.fuse[ifc.rd_row] : '0;
endmodule : pterm_array

/* inc/pld_pkg.sv */
// Shared constants and types of the sum-of-products logic array.
package pld_pkg;
  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int NUM_IN = 12;
  localparam int NUM_MC = 10;
  localparam int NUM_LIT = NUM_IN + NUM_MC;
  localparam int NUM_COL = 2 * NUM_LIT;
  localparam int NUM_PIN = NUM_IN + NUM_MC;
  localparam int MAX_PT = 16;
  localparam int PT_COUNT [NUM_MC] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};
  localparam int PT_BASE [NUM_MC] = '{0, 8, 18, 30, 44, 60, 76, 90, 102, 112};
  localparam int SYNC_CLR_ROW = 120;
  localparam int ASYNC_CLR_ROW = 121;
  localparam int CFG_ROW = 122;
  localparam int NUM_ROWS = 123;
  localparam int ROW_W = 7;
  localparam int CLK_LIT = 0;

  // ****************************************************************
  // Configuration row fields
  // ****************************************************************
  localparam int CFG_REG_POS = 0;
  localparam int CFG_INV_POS = 10;
  localparam int CFG_OE_POS = 20;
  localparam int CFG_W = 30;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 250;
  localparam int IDLE_NS = 1000;
  localparam int IDLE_CYCLES = (IDLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 16;

  typedef logic [NUM_COL-1:0] row_t;
endpackage : pld_pkg

/* inc/pterm_if.sv */
// Connection between the pin control logic and the product-term array.
`timescale 1ns/100ps
interface pterm_if;
  logic [pld_pkg::NUM_COL-1:0] cols;
  logic wr_en;
  logic erase;
  logic [pld_pkg::ROW_W-1:0] wr_row;
  pld_pkg::row_t wr_data;
  logic [pld_pkg::ROW_W-1:0] rd_row;
  pld_pkg::row_t rd_data;
  logic [pld_pkg::NUM_MC-1:0] sums;
  logic sync_clr;
  logic async_clr;
  logic [pld_pkg::CFG_W-1:0] cfg;
  modport ctrl (output cols, wr_en, erase, wr_row, wr_data, rd_row,
                input rd_data, sums, sync_clr, async_clr, cfg);
  modport arr (input cols, wr_en, erase, wr_row, wr_data, rd_row,
               output rd_data, sums, sync_clr, async_clr, cfg);
endinterface : pterm_if
